// ==== core/spwm_pkg.sv ====
package spwm_pkg;

  // register offsets (byte addresses on the original 8-bit map)
  localparam logic [15:0] OFS_D_SETPOINT   = 16'h4090;
  localparam logic [15:0] OFS_Q_SETPOINT   = 16'h4092;
  localparam logic [15:0] OFS_KP           = 16'h4094;
  localparam logic [15:0] OFS_KI           = 16'h4096;
  localparam logic [15:0] OFS_BUS_VOLTAGE  = 16'h4098;
  localparam logic [15:0] OFS_CONTROL      = 16'h40a0;
  localparam logic [15:0] OFS_RAMP_SPEED   = 16'h40a8;
  localparam logic [15:0] OFS_RAMP_ACCEL   = 16'h40aa;
  localparam logic [15:0] OFS_RAMP_LENGTH  = 16'h40ac;
  localparam logic [15:0] OFS_D_MAX        = 16'h40b0;
  localparam logic [15:0] OFS_D_MIN        = 16'h40b2;
  localparam logic [15:0] OFS_Q_MAX        = 16'h40b4;
  localparam logic [15:0] OFS_Q_MIN        = 16'h40b6;
  localparam logic [15:0] OFS_D_VOLT       = 16'h40b8;
  localparam logic [15:0] OFS_Q_VOLT       = 16'h40ba;
  localparam logic [15:0] OFS_D_CURR       = 16'h40bc;
  localparam logic [15:0] OFS_Q_CURR       = 16'h40be;
  localparam logic [15:0] OFS_BETA_CURR    = 16'h40c0;
  localparam logic [15:0] OFS_BETA_VOLT    = 16'h40c2;
  localparam logic [15:0] OFS_ALPHA_VOLT   = 16'h40c4;
  localparam logic [15:0] OFS_PHB_CURR     = 16'h40c8;
  localparam logic [15:0] OFS_PHA_CURR     = 16'h40ca;
  localparam logic [15:0] OFS_ANGLE        = 16'h40cc;
  localparam logic [15:0] OFS_PHA_PEAK     = 16'h40da;
  localparam logic [15:0] OFS_PHB_PEAK     = 16'h40dc;

  // control register fields
  localparam int CTL_RAMP_EN_BIT  = 0;
  localparam int CTL_PEAK_CLR_BIT = 1;
  localparam int CTL_D_PI_OFF_BIT = 2;
  localparam int CTL_Q_PI_OFF_BIT = 3;

  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [7:0]  RST_LENGTH   = 8'h00;
  localparam logic [31:0] RST_SPEED    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
  localparam int          RAMP_SHIFT   = 8;
  localparam int          KP_FRAC      = 12;
  localparam int          KI_FRAC      = 15;
  localparam int          BUS_FLT_SH   = 4;
  localparam logic [15:0] S16_MAX      = 16'h7fff;
  localparam logic [15:0] S16_MIN      = 16'h8000;

  typedef struct packed {
    logic        valid;
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] d_curr;
    logic [15:0] q_curr;
    logic [15:0] beta_curr;
    logic [15:0] alpha_volt;
    logic [15:0] beta_volt;
    logic [14:0] bus_raw;
  } sample_t;

  typedef struct packed {
    logic [15:0] d_volt;
    logic [15:0] q_volt;
    logic [15:0] angle;
  } modulation_t;

endpackage

// ==== core/pi_axis.sv ====
`timescale 1ns/10ps
`default_nettype none
// one PI axis: saturating integrator, proportional term, output clamp
module pi_axis
  import spwm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // control
  input  wire logic        step,
  input  wire logic        enable,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  // operands
  input  wire logic [15:0] setpoint,
  input  wire logic [15:0] feedback,
  input  wire logic [14:0] kp,
  input  wire logic [14:0] ki,
  input  wire logic [15:0] lim_max,
  input  wire logic [15:0] lim_min,
  // result
  output logic      [15:0] out_q
);
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sd32767)
      sat16 = S16_MAX;
    else if (v < -48'sd32768)
      sat16 = S16_MIN;
    else
      sat16 = v[15:0];
  endfunction

  logic        [15:0] integ_q;
  logic signed [16:0] err;
  logic signed [47:0] p_term;
  logic signed [47:0] i_add;
  logic        [15:0] integ_raw;
  logic        [15:0] integ_d;
  logic        [15:0] sum_raw;
  logic        [15:0] out_d;

  assign err     = $signed({setpoint[15], setpoint}) -
                   $signed({feedback[15], feedback});
  assign p_term  = (48'(err) * $signed({33'h0, kp})) >>> KP_FRAC;
  assign i_add   = (48'(err) * $signed({33'h0, ki})) >>> KI_FRAC;
  // saturate, then clamp to limits, never wrap
  assign integ_raw = sat16(48'($signed(integ_q)) + i_add);
  assign integ_d   = ($signed(integ_raw) > $signed(lim_max)) ? lim_max :
                     ($signed(integ_raw) < $signed(lim_min)) ? lim_min :
                     integ_raw;
  assign sum_raw   = sat16(48'($signed(integ_d)) + p_term);
  assign out_d     = ($signed(sum_raw) > $signed(lim_max)) ? lim_max :
                     ($signed(sum_raw) < $signed(lim_min)) ? lim_min :
                     sum_raw;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      integ_q <= RST_WORD;
      out_q   <= RST_WORD;
    end else if (load) begin
      integ_q <= load_val;
      out_q   <= load_val;
    end else if (step && enable) begin
      integ_q <= integ_d;
      out_q   <= out_d;
    end
  end

  pi_in_limits_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $past(step && enable && !load) && $signed(lim_min) <= $signed(lim_max)
    && $stable(lim_max) && $stable(lim_min)
    |-> $signed(out_q) <= $signed(lim_max)
        && $signed(out_q) >= $signed(lim_min))
    else $error("pi output outside limits");

endmodule
`default_nettype wire

// ==== core/spwm_angle_pi_datapath.sv ====
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module spwm_angle_pi_datapath
  import spwm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // pwm timer and adc side
  input  wire logic        pwm_cycle,
  input  wire sample_t     sample,
  // modulation stage
  output modulation_t      modulation,
  output logic             ramp_active
);
  // register state
  logic [15:0] d_setpoint_q, q_setpoint_q;
  logic [14:0] kp_q, ki_q;
  logic [15:0] accel_q;
  logic [7:0]  length_q;
  logic [15:0] d_max_q, d_min_q, q_max_q, q_min_q;
  logic [15:0] d_comp_q, q_comp_q;
  logic [31:0] speed_q;
  logic [15:0] angle_q;
  logic [15:0] ramp_cnt_q;
  logic        ramp_en_q, peak_clr_q, d_off_q, q_off_q;
  logic [15:0] pha_q, phb_q, dcur_q, qcur_q, bcur_q, av_q, bv_q;
  logic [15:0] pha_pk_q, phb_pk_q;
  logic [19:0] bus_acc_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [15:0] d_volt, q_volt;

  // bus decode: one wait cycle; writes land on the answering edge
  wire         req     = (avs_read || avs_write) && !ack_q;
  wire         wr      = avs_write && ack_q;
  wire  [15:0] wdat    = avs_writedata[15:0];
  wire         lo_be   = avs_byteenable[0] && avs_byteenable[1];
  wire         wr_ok   = wr && lo_be;
  wire         w_dset  = wr_ok && avs_address == OFS_D_SETPOINT;
  wire         w_qset  = wr_ok && avs_address == OFS_Q_SETPOINT;
  wire         w_kp    = wr_ok && avs_address == OFS_KP;
  wire         w_ki    = wr_ok && avs_address == OFS_KI;
  wire         w_ctl   = wr_ok && avs_address == OFS_CONTROL;
  wire         w_speed = wr_ok && avs_address == OFS_RAMP_SPEED;
  wire         w_accel = wr_ok && avs_address == OFS_RAMP_ACCEL;
  wire         w_len   = wr && avs_byteenable[0] &&
                         avs_address == OFS_RAMP_LENGTH;
  wire         w_dmax  = wr_ok && avs_address == OFS_D_MAX;
  wire         w_dmin  = wr_ok && avs_address == OFS_D_MIN;
  wire         w_qmax  = wr_ok && avs_address == OFS_Q_MAX;
  wire         w_qmin  = wr_ok && avs_address == OFS_Q_MIN;
  wire         w_dv    = wr_ok && avs_address == OFS_D_VOLT;
  wire         w_qv    = wr_ok && avs_address == OFS_Q_VOLT;
  wire         w_dcmp  = wr_ok && avs_address == OFS_BETA_VOLT;
  wire         w_qcmp  = wr_ok && avs_address == OFS_ALPHA_VOLT;
  wire         w_ang   = wr_ok && avs_address == OFS_ANGLE;

  // ramp sequencing
  wire  [15:0] ramp_limit = {length_q, 8'h00};
  wire         ramp_step  = pwm_cycle && ramp_en_q;
  wire         ramp_done  = ramp_step &&
                            (ramp_cnt_q + 16'h0001 >= ramp_limit);
  wire  [31:0] accel_ext  = {16'h0000, accel_q};
  wire  [31:0] speed_d    = speed_q + {{16{accel_ext[15]}}, accel_ext[15:0]};
  wire  [15:0] angle_d    = angle_q + speed_q[31:16];

  // peak tracking and bus voltage filter
  wire         pk_a_new = $signed(sample.phase_a) > $signed(pha_pk_q);
  wire         pk_b_new = $signed(sample.phase_b) > $signed(phb_pk_q);
  wire  [19:0] bus_in   = {5'h00, sample.bus_raw};
  wire  [19:0] bus_d    = bus_acc_q - (bus_acc_q >> BUS_FLT_SH) + bus_in;
  wire  [14:0] bus_flt  = bus_acc_q[BUS_FLT_SH +: 15];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      d_setpoint_q <= RST_WORD;
      q_setpoint_q <= RST_WORD;
      kp_q         <= RST_WORD[14:0];
      ki_q         <= RST_WORD[14:0];
      accel_q      <= RST_WORD;
      length_q     <= RST_LENGTH;
      d_max_q      <= RST_WORD;
      d_min_q      <= RST_WORD;
      q_max_q      <= RST_WORD;
      q_min_q      <= RST_WORD;
      d_comp_q     <= RST_WORD;
      q_comp_q     <= RST_WORD;
    end else begin
      if (w_dset) d_setpoint_q <= wdat;
      if (w_qset) q_setpoint_q <= wdat;
      if (w_kp) kp_q <= wdat[14:0];
      if (w_ki) ki_q <= wdat[14:0];
      if (w_accel) accel_q <= wdat;
      if (w_len) length_q <= avs_writedata[7:0];
      if (w_dmax) d_max_q <= wdat;
      if (w_dmin) d_min_q <= wdat;
      if (w_qmax) q_max_q <= wdat;
      if (w_qmin) q_min_q <= wdat;
      if (w_dcmp) d_comp_q <= wdat;
      if (w_qcmp) q_comp_q <= wdat;
    end
  end

  // control bits; hardware completion wins over software set in same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ramp_en_q  <= 1'b0;
      peak_clr_q <= 1'b0;
      d_off_q    <= 1'b0;
      q_off_q    <= 1'b0;
    end else begin
      if (ramp_done)
        ramp_en_q <= 1'b0;
      else if (w_ctl)
        ramp_en_q <= wdat[CTL_RAMP_EN_BIT];
      if (w_ctl) begin
        peak_clr_q <= wdat[CTL_PEAK_CLR_BIT];
        d_off_q    <= wdat[CTL_D_PI_OFF_BIT];
        q_off_q    <= wdat[CTL_Q_PI_OFF_BIT];
      end
    end
  end

  // ramp engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      speed_q    <= RST_SPEED;
      angle_q    <= RST_WORD;
      ramp_cnt_q <= RST_WORD;
    end else begin
      if (w_speed)
        speed_q <= {wdat, 16'h0000};
      else if (ramp_step)
        speed_q <= speed_d;
      if (w_ang)
        angle_q <= wdat;
      else if (pwm_cycle)
        angle_q <= angle_d;
      if (ramp_step && !ramp_done)
        ramp_cnt_q <= ramp_cnt_q + 16'h0001;
      else if (!ramp_en_q || ramp_done)
        ramp_cnt_q <= RST_WORD;
    end
  end

  // observed values and peaks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pha_q     <= RST_WORD;
      phb_q     <= RST_WORD;
      dcur_q    <= RST_WORD;
      qcur_q    <= RST_WORD;
      bcur_q    <= RST_WORD;
      av_q      <= RST_WORD;
      bv_q      <= RST_WORD;
      pha_pk_q  <= RST_WORD;
      phb_pk_q  <= RST_WORD;
      bus_acc_q <= 20'h00000;
    end else begin
      if (sample.valid) begin
        pha_q     <= sample.phase_a;
        phb_q     <= sample.phase_b;
        dcur_q    <= sample.d_curr;
        qcur_q    <= sample.q_curr;
        bcur_q    <= sample.beta_curr;
        av_q      <= sample.alpha_volt;
        bv_q      <= sample.beta_volt;
        bus_acc_q <= bus_d;
      end
      if (peak_clr_q) begin
        pha_pk_q <= RST_WORD;
        phb_pk_q <= RST_WORD;
      end else if (sample.valid) begin
        if (pk_a_new) pha_pk_q <= sample.phase_a;
        if (pk_b_new) phb_pk_q <= sample.phase_b;
      end
    end
  end

  pi_axis u_pi_d (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .step     (pwm_cycle),
    .enable   (!d_off_q),
    .load     (w_dv),
    .load_val (wdat),
    .setpoint (d_setpoint_q),
    .feedback (dcur_q),
    .kp       (kp_q),
    .ki       (ki_q),
    .lim_max  (d_max_q),
    .lim_min  (d_min_q),
    .out_q    (d_volt)
  );

  pi_axis u_pi_q (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .step     (pwm_cycle),
    .enable   (!q_off_q),
    .load     (w_qv),
    .load_val (wdat),
    .setpoint (q_setpoint_q),
    .feedback (qcur_q),
    .kp       (kp_q),
    .ki       (ki_q),
    .lim_max  (q_max_q),
    .lim_min  (q_min_q),
    .out_q    (q_volt)
  );

  // compensated voltages to the modulator, registered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      modulation <= '0;
    end else begin
      modulation.d_volt <= d_volt + d_comp_q;
      modulation.q_volt <= q_volt + q_comp_q;
      modulation.angle  <= angle_q;
    end
  end
  assign ramp_active = ramp_en_q;

  // read mux; write-only cells read zero, shared offsets show observed
  logic [15:0] rmux;
  always_comb begin
    rmux = UNMAPPED_VAL[15:0];
    unique case (avs_address)
      OFS_D_SETPOINT:  rmux = d_setpoint_q;
      OFS_Q_SETPOINT:  rmux = q_setpoint_q;
      OFS_KP:          rmux = {1'b0, kp_q};
      OFS_KI:          rmux = {1'b0, ki_q};
      OFS_BUS_VOLTAGE: rmux = {1'b0, bus_flt};
      OFS_CONTROL:     rmux = {12'h000, q_off_q, d_off_q, peak_clr_q,
                               ramp_en_q};
      OFS_RAMP_SPEED:  rmux = speed_q[31:16];
      OFS_RAMP_LENGTH: rmux = {8'h00, length_q};
      OFS_Q_MAX:       rmux = q_max_q;
      OFS_Q_MIN:       rmux = q_min_q;
      OFS_D_VOLT:      rmux = d_volt;
      OFS_Q_VOLT:      rmux = q_volt;
      OFS_D_CURR:      rmux = dcur_q;
      OFS_Q_CURR:      rmux = qcur_q;
      OFS_BETA_CURR:   rmux = bcur_q;
      OFS_BETA_VOLT:   rmux = bv_q;
      OFS_ALPHA_VOLT:  rmux = av_q;
      OFS_PHB_CURR:    rmux = phb_q;
      OFS_PHA_CURR:    rmux = pha_q;
      OFS_ANGLE:       rmux = angle_q;
      OFS_PHA_PEAK:    rmux = pha_pk_q;
      OFS_PHB_PEAK:    rmux = phb_pk_q;
      default:         rmux = UNMAPPED_VAL[15:0];
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= UNMAPPED_VAL;
    end else begin
      ack_q <= req;
      if (avs_read && req)
        rdata_q <= {16'h0000, rmux};
    end
  end
  assign avs_waitrequest = !ack_q;
  assign avs_readdata    = rdata_q;

  ramp_stops_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ramp_done |=> !ramp_en_q)
    else $error("ramp enable not cleared at limit");
  ramp_count_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ramp_en_q |-> ramp_cnt_q < ramp_limit || length_q == 8'h00)
    else $error("ramp counter beyond limit");
  speed_step_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ramp_step && !w_speed |=> speed_q == $past(speed_d))
    else $error("speed not accumulated");
  angle_step_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pwm_cycle && !w_ang
    |=> angle_q == $past(angle_q) + $past(speed_q[31:16]))
    else $error("angle step wrong");
  angle_hold_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !pwm_cycle && !w_ang |=> $stable(angle_q))
    else $error("angle moved off pwm cycle");
  angle_load_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    w_ang |=> angle_q == $past(wdat))
    else $error("angle write not loaded");
  peak_keep_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !peak_clr_q |=> $signed(pha_pk_q) >= $signed($past(pha_pk_q)))
    else $error("peak fell without clear");
  peak_keep_b_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !peak_clr_q |=> $signed(phb_pk_q) >= $signed($past(phb_pk_q)))
    else $error("phase b peak fell without clear");
  gain_top_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ack_q && avs_read && avs_address == OFS_KP |-> avs_readdata[15] == 1'b0)
    else $error("gain top bit set");
  ki_top_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ack_q && avs_read && avs_address == OFS_KI |-> avs_readdata[15] == 1'b0)
    else $error("integral gain top bit set");
  comp_sum_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ##1 modulation.d_volt == $past(d_volt) + $past(d_comp_q))
    else $error("d compensation sum wrong");
  comp_sum_q_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ##1 modulation.q_volt == $past(q_volt) + $past(q_comp_q))
    else $error("q compensation sum wrong");
  accel_high_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ack_q && avs_read && avs_address == OFS_RAMP_ACCEL
    |-> avs_readdata == UNMAPPED_VAL)
    else $error("acceleration reads nonzero");

endmodule
`default_nettype wire

// ==== verification/pwm_adc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// pwm timer tick and adc conversion source
module pwm_adc_model
  import spwm_pkg::*;
(
  // clock
  input  wire logic clk_sys,
  // to datapath
  output logic      pwm_cycle,
  output sample_t   sample
);
  initial begin
    pwm_cycle = 1'b0;
    sample    = '0;
  end
  // one period tick, then idle cycles
  task automatic pulse(input int gap);
    @(posedge clk_sys);
    pwm_cycle <= 1'b1;
    @(posedge clk_sys);
    pwm_cycle <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask
  // one-cycle result; inverse pattern once released
  task automatic send(input sample_t s);
    s.valid = 1'b1;
    @(posedge clk_sys);
    sample <= s;
    @(posedge clk_sys);
    sample <= ~s;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb
  import spwm_pkg::*;
;
  logic        clk_sys;
  logic        sys_rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pwm_cycle;
  sample_t     sample;
  modulation_t modulation;
  logic        ramp_active;
  int          err_count = 0;
  int          n_compared = 0;
  int          seed = 23;
  logic [15:0] t_adr [13] = '{OFS_D_SETPOINT, OFS_Q_SETPOINT, OFS_KP,
    OFS_KI, OFS_Q_MAX, OFS_Q_MIN, OFS_RAMP_LENGTH, OFS_RAMP_ACCEL,
    OFS_D_MAX, OFS_D_MIN, 16'h40e0, OFS_D_CURR, OFS_PHA_PEAK};
  logic [15:0] t_wr [13] = '{16'h8001, 16'h7ffe, 16'hffff, 16'hffff,
    16'h1234, 16'hedcb, 16'h00a5, 16'h5555, 16'h1111, 16'h2222,
    16'hbeef, 16'hffff, 16'hffff};
  logic [15:0] t_exp [13] = '{16'h8001, 16'h7ffe, 16'h7fff, 16'h7fff,
    16'h1234, 16'hedcb, 16'h00a5, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  logic [15:0] ro_adr [14] = '{OFS_BUS_VOLTAGE, OFS_D_VOLT, OFS_Q_VOLT,
    OFS_D_CURR, OFS_Q_CURR, OFS_BETA_CURR, OFS_BETA_VOLT, OFS_ALPHA_VOLT,
    OFS_PHB_CURR, OFS_PHA_CURR, OFS_ANGLE, OFS_PHA_PEAK, OFS_PHB_PEAK,
    OFS_RAMP_SPEED};
  logic [15:0] kp_t [4] = '{16'h1000, 16'h1000, 16'h7fff, 16'h2000};
  logic [15:0] ds_t [4] = '{16'h1000, 16'h0400, 16'hf000, 16'h0200};
  logic [15:0] qs_t [4] = '{16'h8000, 16'h0200, 16'h8000, 16'h0300};

  spwm_angle_pi_datapath uut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pwm_cycle(pwm_cycle),
    .sample(sample),
    .modulation(modulation),
    .ramp_active(ramp_active)
  );
  pwm_adc_model pm (
    .clk_sys(clk_sys),
    .pwm_cycle(pwm_cycle),
    .sample(sample)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      tally_and_finish;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask

  // proportional-only controller with saturation and limits
  function automatic logic [15:0] pi_out(int sp, int kp, int lo, int hi);
    int v;
    v = (sp * kp) >>> 12;
    v = (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
    v = (v > hi) ? hi : (v < lo) ? lo : v;
    return v[15:0];
  endfunction

  initial begin
    logic [31:0] spd;
    logic [15:0] ang;
    logic [15:0] pka;
    logic [15:0] pkb;
    logic [18:0] acc;
    sample_t     s;
    int          cnt;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (ro_adr[i]) rd(ro_adr[i], 16'h0000);
    foreach (t_adr[i]) rd(t_adr[i], 16'h0000);
    $display("reset values done");
    foreach (t_adr[i]) begin
      wr(t_adr[i], t_wr[i]);
      rd(t_adr[i], t_exp[i]);
    end
    $display("register access done");
    wr(OFS_KI, 16'h0000);
    wr(OFS_D_MAX, 16'h0800);
    wr(OFS_D_MIN, 16'hf800);
    wr(OFS_Q_MAX, 16'h0400);
    wr(OFS_Q_MIN, 16'h8000);
    pm.send('0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_KP, kp_t[i]);
      wr(OFS_D_SETPOINT, ds_t[i]);
      wr(OFS_Q_SETPOINT, qs_t[i]);
      pm.pulse(2);
      rd(OFS_D_VOLT, pi_out($signed(ds_t[i]), kp_t[i], -2048, 2048));
      rd(OFS_Q_VOLT, pi_out($signed(qs_t[i]), kp_t[i], -32768, 1024));
    end
    $display("pi controller done");
    wr(OFS_CONTROL, 16'h000c);
    wr(OFS_D_VOLT, 16'h1234);
    wr(OFS_Q_VOLT, 16'hfedc);
    wr(OFS_BETA_VOLT, 16'h0011);
    wr(OFS_ALPHA_VOLT, 16'h0022);
    pm.pulse(3);
    rd(OFS_D_VOLT, 16'h1234);
    rd(OFS_Q_VOLT, 16'hfedc);
    chk(modulation.d_volt, 16'h1245);
    chk(modulation.q_volt, 16'hfefe);
    $display("voltage compensation done");
    wr(OFS_RAMP_ACCEL, 16'h4000);
    wr(OFS_RAMP_SPEED, 16'h0010);
    wr(OFS_RAMP_LENGTH, 16'h0001);
    wr(OFS_ANGLE, 16'h7ff0);
    rd(OFS_ANGLE, 16'h7ff0);
    spd = 32'h0010_0000;
    ang = 16'h7ff0;
    cnt = 0;
    wr(OFS_CONTROL, 16'h000d);
    @(posedge clk_sys);
    chk({15'h0000, ramp_active}, 16'h0001);
    for (int i = 1; i <= 260; i++) begin
      pm.pulse(2);
      ang = ang + spd[31:16];
      if (cnt < 256) begin
        spd = spd + 32'h0000_4000;
        cnt++;
      end
      chk({15'h0000, ramp_active}, {15'h0000, cnt < 256});
      if (i % 64 == 0 || i > 254) rd(OFS_ANGLE, ang);
    end
    rd(OFS_RAMP_SPEED, spd[31:16]);
    chk(modulation.angle, ang);
    $display("angle ramp done");
    pka = 16'h0000;
    pkb = 16'h0000;
    acc = 19'h00000;
    for (int i = 0; i < 8; i++) begin
      s = {$random(seed), $random(seed), $random(seed), $random(seed)};
      s.phase_a[15] = 1'b0;
      s.phase_b[15] = 1'b0;
      pm.send(s);
      pm.pulse(1);
      pka = (s.phase_a > pka) ? s.phase_a : pka;
      pkb = (s.phase_b > pkb) ? s.phase_b : pkb;
      acc = acc + 19'(s.bus_raw) - (acc >> 4);
      rd(OFS_PHA_CURR, s.phase_a);
      rd(OFS_PHB_CURR, s.phase_b);
      rd(OFS_D_CURR, s.d_curr);
      rd(OFS_Q_CURR, s.q_curr);
      rd(OFS_BETA_CURR, s.beta_curr);
      rd(OFS_ALPHA_VOLT, s.alpha_volt);
      rd(OFS_BETA_VOLT, s.beta_volt);
      rd(OFS_PHA_PEAK, pka);
      rd(OFS_PHB_PEAK, pkb);
      rd(OFS_BUS_VOLTAGE, {1'b0, acc[18:4]});
    end
    wr(OFS_PHA_CURR, 16'h5a5a);
    rd(OFS_PHA_CURR, s.phase_a);
    wr(OFS_CONTROL, 16'h000e);
    wr(OFS_CONTROL, 16'h000c);
    rd(OFS_PHA_PEAK, 16'h0000);
    rd(OFS_PHB_PEAK, 16'h0000);
    $display("samples and peaks done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
